//--- cics_pkg.sv
/*
  Shared constants for the codec init/calibration sequencer: bus map,
  register fields, reset values, sequence lengths and the sample-period
  divider table. Assumes both ends run on one 40 MHz clock.
*/
`default_nettype none
package cics_pkg;
  // Clock rate and host settle delay
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned SETTLE_TIME_MS  = 1000;
  localparam int unsigned SETTLE_CYCLES   = (CLK_HZ / 1000) * SETTLE_TIME_MS;
  // Direct addresses on the two address pins
  localparam logic [1:0]  ADR_INDEX       = 2'h0;
  localparam logic [1:0]  ADR_DATA        = 2'h1;
  localparam logic [1:0]  ADR_STATUS      = 2'h2;
  // Indexed registers
  localparam logic [1:0]  IDX_IFACE       = 2'h0;
  localparam logic [1:0]  IDX_CLOCK       = 2'h1;
  localparam logic [1:0]  IDX_TEST        = 2'h2;
  localparam logic [1:0]  IDX_MUTE        = 2'h3;
  // Field positions
  localparam int unsigned WINDOW_BIT      = 6;
  localparam int unsigned PLAY_EN_BIT     = 0;
  localparam int unsigned CEN_BIT         = 1;
  localparam int unsigned CAL_EXIT_BIT    = 3;
  localparam int unsigned CAL_ACTIVE_BIT  = 5;
  localparam int unsigned CALDONE_BIT     = 0;
  localparam int unsigned FIRST_AUX_MUTE_BIT  = 0;
  localparam int unsigned SECOND_AUX_MUTE_BIT = 1;
  localparam int unsigned MIX_MUTE_BIT    = 2;
  // Values after reset and the busy answer
  localparam logic [7:0]  BUSY_READ       = 8'h80;
  localparam logic [7:0]  IFACE_RESET     = 8'h08;
  localparam logic [3:0]  CLOCK_RESET     = 4'h0;
  localparam logic [2:0]  MUTE_RESET      = 3'h0;
  // Sequence lengths in sample periods
  localparam int unsigned CNT_W           = 9;
  localparam logic [8:0]  INIT_PERIODS    = 9'h020;
  localparam logic [8:0]  RESYNC_PERIODS  = 9'h010;
  localparam logic [8:0]  CAL_DELAY_PERIODS = 9'h002;
  localparam logic [8:0]  CAL_POWERUP_PERIODS = 9'h180;
  localparam logic [8:0]  CAL_RATE_PERIODS = 9'h080;
  // Host strobe timing in clock cycles
  localparam logic [3:0]  STROBE_CYCLES   = 4'h8;
  localparam logic [3:0]  HOLD_CYCLES     = 4'h4;

  // Clock cycles per sample period for a divide select and source
  function automatic logic [11:0] period_cycles(input logic [2:0] sel,
                                                input logic       src);
    logic [11:0] base;
    base = src ? 12'h028 : 12'h020;
    return base + {6'h00, sel, 3'h0};
  endfunction
endpackage
`default_nettype wire

//--- cics_bus_if.sv
/*
  Parallel host bus between codec sequencer and host. Resolves the shared
  data byte from the two output enables, low meaning driven. Assumes at
  most one side drives; an undriven bus reads as zero.
*/
`default_nettype none
interface cics_bus_if;
  logic       power_down_n;    // Active-low power down from host
  logic       cs_n;            // Chip select, low active
  logic       rd_n;            // Read strobe, low active
  logic       wr_n;            // Write strobe, low active
  logic [1:0] addr;            // Direct address
  logic [7:0] host_data;       // Host data out
  logic       host_data_oe_n;  // Host drives data when low
  logic [7:0] dev_data;        // Device data out
  logic       dev_data_oe_n;   // Device drives data when low
  logic [7:0] data;            // Resolved bus byte

  // Resolution of the shared byte
  assign data = !dev_data_oe_n  ? dev_data  :
                !host_data_oe_n ? host_data : 8'h00;

  modport device (
    input  power_down_n, cs_n, rd_n, wr_n, addr, data,
    output dev_data, dev_data_oe_n
  );
  modport host (
    output power_down_n, cs_n, rd_n, wr_n, addr, host_data, host_data_oe_n,
    input  data
  );
endinterface
`default_nettype wire

//--- cics_device.sv
/*
  Codec control sequencer, device end: power-down, initialization,
  autocalibration on leaving the mode-change window, resync after a clock
  change, and the small indexed register set the host polls.
  Assumes bus pins are asynchronous to clk and the host holds strobes
  long enough for the two-stage synchronisers.
*/
`default_nettype none
module cics_device
  import cics_pkg::*;
(
  input  wire logic clk,                    // 40 MHz clock
  input  wire logic resetn,                 // Asynchronous reset, low
  input  wire logic ce,                     // Clock enable
  cics_bus_if.device bus,                   // Host parallel bus
  output logic      calibration_active,     // Calibration running
  output logic      playback_request,       // One playback transfer
  output logic      capture_request,        // One capture transfer
  output logic      dac_mute,               // DAC outputs muted
  output logic      adc_data_valid,         // ADC words meaningful
  output logic      dac_samples_accepted,   // DAC samples used
  output logic      analog_enable,          // Analog sections powered
  output logic      offsets_valid,          // Offsets calibrated
  output logic      first_auxiliary_input_mute,  // First aux muted
  output logic      second_auxiliary_input_mute, // Second aux muted
  output logic      digital_mix_mute        // Digital mix muted
);
  import cics_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  typedef enum logic [5:0] {
    ST_OFF      = 6'h01,
    ST_INIT     = 6'h02,
    ST_RUN      = 6'h04,
    ST_RESYNC   = 6'h08,
    ST_CAL_WAIT = 6'h10,
    ST_CAL      = 6'h20
  } cics_state_t;

  logic [13:0] pin_meta;         // First stage, read only by second
  logic [13:0] pin_sync;         // Second stage
  logic        pwr_s;            // Synced power_down_n
  logic        cs_n_s;           // Synced chip select
  logic        rd_n_s;           // Synced read strobe
  logic        wr_n_s;           // Synced write strobe
  logic [1:0]  addr_s;           // Synced address
  logic [7:0]  data_s;           // Synced data byte

  // Two flops on every pin; reset value looks like an idle, powered-down bus
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta <= 14'h1c00;
      pin_sync <= 14'h1c00;
    end
    else if (ce)
    begin
      pin_meta <= {bus.power_down_n, bus.cs_n, bus.rd_n, bus.wr_n,
                   bus.addr, bus.data};
      pin_sync <= pin_meta;
    end
  end

  assign {pwr_s, cs_n_s, rd_n_s, wr_n_s, addr_s, data_s} = pin_sync;

  ////////////////////////////////////////////////////////////////////////
  // State and registers
  cics_state_t       state;          // Sequencer state
  cics_state_t       next_state;     // Sequencer next state
  logic [CNT_W-1:0]  cnt;            // Sample periods in state
  logic [11:0]       div_cnt;        // Clock cycles in sample period
  logic              tick;           // One-cycle sample tick
  logic              wr_prev;        // Write strobe last cycle
  logic [1:0]        index_reg;      // Indexed register pointer
  logic              mc_window;      // mode_change_window bit
  logic [7:0]        iface_reg;      // playback/capture enable, calibrate_on_exit
  logic [3:0]        clock_reg;      // {clock_divide_select, source}
  logic [2:0]        mute_reg;       // First aux, second aux, mix mutes
  logic              first_cal;      // Next calibration is power-up one
  logic              cal_done;       // Offsets stored at least once

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire         pd_active   = !pwr_s;
  wire         busy        = (state == ST_INIT) || (state == ST_RESYNC);
  wire         in_cal      = (state == ST_CAL_WAIT) || (state == ST_CAL);
  wire         wr_rise     = wr_n_s && !wr_prev && !cs_n_s;
  wire         wr_ok       = wr_rise && !busy && (state != ST_OFF);
  wire         rd_act      = !rd_n_s && !cs_n_s && (state != ST_OFF);
  wire         wr_index    = wr_ok && (addr_s == ADR_INDEX);
  wire         wr_data     = wr_ok && (addr_s == ADR_DATA);
  wire         window_fall = wr_index && mc_window && !data_s[WINDOW_BIT];
  wire         clock_wr    = wr_data && (index_reg == IDX_CLOCK) && mc_window;
  wire         clock_chg   = clock_wr && (data_s[3:0] != clock_reg);
  wire         cal_on_exit = iface_reg[CAL_EXIT_BIT];
  wire         play_en     = iface_reg[PLAY_EN_BIT];
  wire         cen         = iface_reg[CEN_BIT];
  wire [11:0]  period      = period_cycles(clock_reg[3:1], clock_reg[0]);
  wire [CNT_W-1:0] cal_len = first_cal ? CAL_POWERUP_PERIODS
                                       : CAL_RATE_PERIODS;
  wire [CNT_W-1:0] limit   = (state == ST_INIT)     ? INIT_PERIODS :
                             (state == ST_RESYNC)   ? RESYNC_PERIODS :
                             (state == ST_CAL_WAIT) ? CAL_DELAY_PERIODS :
                             cal_len;
  wire         period_end  = tick && (cnt == limit - 9'h001);

  // Register read multiplexer; busy states answer the fixed busy byte
  wire [7:0]   idx_read    = (index_reg == IDX_IFACE) ? iface_reg :
                             (index_reg == IDX_CLOCK) ? {4'h0, clock_reg} :
                             (index_reg == IDX_TEST)  ?
                               {2'h0, (state == ST_CAL), 4'h0, cal_done} :
                             {5'h00, mute_reg};
  wire [7:0]   read_mux    = busy ? BUSY_READ :
                             (addr_s == ADR_INDEX)  ? {1'b0, mc_window, 4'h0, index_reg} :
                             (addr_s == ADR_DATA)   ? idx_read :
                             (addr_s == ADR_STATUS) ?
                               {6'h00, in_cal, state == ST_RUN} :
                             8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Next state; power down overrides everything
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_OFF:      if (pwr_s) next_state = ST_INIT;
      ST_INIT:     if (period_end) next_state = ST_RUN;
      ST_RUN:
      begin
        if (clock_chg)
          next_state = ST_RESYNC;
        else if (window_fall && cal_on_exit)
          next_state = ST_CAL_WAIT;
      end
      ST_RESYNC:   if (period_end) next_state = ST_RUN;
      ST_CAL_WAIT: if (period_end) next_state = ST_CAL;
      ST_CAL:      if (period_end) next_state = ST_RUN;
      default:     next_state = ST_OFF;
    endcase
    if (pd_active)
      next_state = ST_OFF;
  end

  // State and sample-period counter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_OFF;
      cnt   <= '0;
    end
    else if (ce)
    begin
      state <= next_state;
      if (next_state != state)
        cnt <= '0;
      else if (tick)
        cnt <= cnt + 9'h001;
    end
  end

  // Sample tick from selected source and divider; stopped when off
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_cnt <= 12'h000;
      tick    <= 1'b0;
    end
    else if (ce)
    begin
      if (state == ST_OFF || div_cnt >= period - 12'h001)
        div_cnt <= 12'h000;
      else
        div_cnt <= div_cnt + 12'h001;
      tick <= (state != ST_OFF) && (div_cnt >= period - 12'h001);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host-visible registers; held at defaults while off or initialising
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_prev   <= 1'b1;
      index_reg <= 2'h0;
      mc_window <= 1'b0;
      iface_reg <= IFACE_RESET;
      clock_reg <= CLOCK_RESET;
      mute_reg  <= MUTE_RESET;
    end
    else if (ce)
    begin
      wr_prev <= wr_n_s;
      if (state == ST_OFF || state == ST_INIT)
      begin
        // Defaults reload every cycle while off and all through init
        index_reg <= 2'h0;
        mc_window <= 1'b0;
        iface_reg <= IFACE_RESET;
        clock_reg <= CLOCK_RESET;
        mute_reg  <= MUTE_RESET;
      end
      else
      begin
        if (wr_index)
        begin
          index_reg <= data_s[1:0];
          mc_window <= data_s[WINDOW_BIT];
        end
        if (wr_data && index_reg == IDX_IFACE)
          iface_reg <= data_s;
        // Both clock fields change together from one write
        if (clock_wr)
          clock_reg <= data_s[3:0];
        if (wr_data && index_reg == IDX_MUTE)
          mute_reg <= data_s[2:0];
      end
    end
  end

  // Calibration bookkeeping; offsets only replaced by a finished run
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      first_cal <= 1'b1;
      cal_done  <= 1'b0;
    end
    else if (ce)
    begin
      if (state == ST_OFF)
      begin
        first_cal <= 1'b1;
        cal_done  <= 1'b0;
      end
      else if (state == ST_CAL && period_end)
      begin
        first_cal <= 1'b0;
        cal_done  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus.dev_data                <= 8'h00;
      bus.dev_data_oe_n           <= 1'b1;
      calibration_active          <= 1'b0;
      playback_request            <= 1'b0;
      capture_request             <= 1'b0;
      dac_mute                    <= 1'b1;
      adc_data_valid              <= 1'b0;
      dac_samples_accepted        <= 1'b0;
      analog_enable               <= 1'b0;
      offsets_valid               <= 1'b0;
      first_auxiliary_input_mute  <= 1'b0;
      second_auxiliary_input_mute <= 1'b0;
      digital_mix_mute            <= 1'b0;
    end
    else if (ce)
    begin
      bus.dev_data                <= rd_act ? read_mux : 8'h00;
      bus.dev_data_oe_n           <= !rd_act || pd_active;
      calibration_active          <= (next_state == ST_CAL);
      // Requests only in normal running, so calibration defers them
      playback_request            <= tick && (state == ST_RUN) && play_en;
      capture_request             <= tick && (state == ST_RUN) && cen;
      dac_mute                    <= in_cal || (state != ST_RUN);
      adc_data_valid              <= (state == ST_RUN);
      dac_samples_accepted        <= (state == ST_RUN) && play_en;
      analog_enable               <= !pd_active;
      offsets_valid               <= cal_done;
      first_auxiliary_input_mute  <= mute_reg[FIRST_AUX_MUTE_BIT];
      second_auxiliary_input_mute <= mute_reg[SECOND_AUX_MUTE_BIT];
      digital_mix_mute            <= mute_reg[MIX_MUTE_BIT];
    end
  end
endmodule
`default_nettype wire

//--- cics_host.sv
/*
  Host end of the codec bus: drives power_down_n, waits the settle time,
  polls the index until initialisation ends, then runs single byte read
  and write cycles for the user. Assumes the device synchronises pins.
*/
`default_nettype none
module cics_host
  import cics_pkg::*;
#(
  parameter int unsigned SETTLE = cics_pkg::SETTLE_CYCLES  // Settle cycles
)
(
  input  wire logic       clk,               // 40 MHz clock
  input  wire logic       resetn,            // Asynchronous reset, low
  input  wire logic       ce,                // Clock enable
  input  wire logic       power_up_request,  // Level: release power down
  input  wire logic       cmd_valid,         // Bus cycle requested
  input  wire logic       cmd_write,         // 1 write, 0 read
  input  wire logic [1:0] cmd_addr,          // Direct address
  input  wire logic [7:0] cmd_wdata,         // Write byte
  output logic            cmd_ready,         // Request taken when high
  output logic            rsp_valid,         // One-cycle completion
  output logic [7:0]      rsp_rdata,         // Read byte
  output logic            device_ready,      // Init finished
  cics_bus_if.host        bus                // Codec parallel bus
);
  import cics_pkg::*;

  typedef enum logic [4:0] {
    H_OFF    = 5'h01,
    H_SETTLE = 5'h02,
    H_IDLE   = 5'h04,
    H_STROBE = 5'h08,
    H_HOLD   = 5'h10
  } cics_hstate_t;

  cics_hstate_t state;     // Host sequencer state
  logic [31:0]  wait_cnt;  // Settle and strobe counter
  logic         is_write;  // Current cycle writes
  logic         is_poll;   // Current cycle is the init poll
  logic [7:0]   data_meta; // First stage of bus data
  logic [7:0]   data_s;    // Second stage of bus data

  ////////////////////////////////////////////////////////////////////////
  // Data pin synchroniser
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_meta <= 8'h00;
      data_s    <= 8'h00;
    end
    else if (ce)
    begin
      data_meta <= bus.data;
      data_s    <= data_meta;
    end
  end

  wire start_poll = (state == H_IDLE) && !device_ready;
  wire start_cmd  = (state == H_IDLE) && device_ready && cmd_valid;
  wire strobe_end = (state == H_STROBE) && (wait_cnt[3:0] == STROBE_CYCLES - 4'h1);
  wire hold_end   = (state == H_HOLD) && (wait_cnt[3:0] == HOLD_CYCLES - 4'h1);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and pin drivers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state              <= H_OFF;
      wait_cnt           <= 32'h0;
      is_write           <= 1'b0;
      is_poll            <= 1'b0;
      cmd_ready          <= 1'b0;
      rsp_valid          <= 1'b0;
      rsp_rdata          <= 8'h00;
      device_ready       <= 1'b0;
      bus.power_down_n   <= 1'b0;
      bus.cs_n           <= 1'b1;
      bus.rd_n           <= 1'b1;
      bus.wr_n           <= 1'b1;
      bus.addr           <= 2'h0;
      bus.host_data      <= 8'h00;
      bus.host_data_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      rsp_valid <= 1'b0;
      cmd_ready <= 1'b0;
      unique case (state)
        H_OFF:
        begin
          wait_cnt <= 32'h0;
          if (power_up_request)
          begin
            bus.power_down_n <= 1'b1;
            state            <= H_SETTLE;
          end
        end
        H_SETTLE:
        begin
          // Outputs settle before any access or calibration
          wait_cnt <= wait_cnt + 32'h1;
          if (wait_cnt >= SETTLE - 1)
            state <= H_IDLE;
        end
        H_IDLE:
        begin
          wait_cnt <= 32'h0;
          cmd_ready <= device_ready && !cmd_valid;
          if (start_poll || start_cmd)
          begin
            is_poll            <= start_poll;
            is_write           <= start_cmd && cmd_write;
            bus.addr           <= start_poll ? ADR_INDEX : cmd_addr;
            bus.host_data      <= cmd_wdata;
            bus.host_data_oe_n <= !(start_cmd && cmd_write);
            bus.cs_n           <= 1'b0;
            bus.rd_n           <= !(start_poll || !cmd_write);
            bus.wr_n           <= !(start_cmd && cmd_write);
            cmd_ready          <= start_cmd;
            state              <= H_STROBE;
          end
        end
        H_STROBE:
        begin
          wait_cnt <= wait_cnt + 32'h1;
          if (strobe_end)
          begin
            rsp_rdata <= data_s;
            bus.rd_n  <= 1'b1;
            bus.wr_n  <= 1'b1;
            wait_cnt  <= 32'h0;
            state     <= H_HOLD;
          end
        end
        H_HOLD:
        begin
          // Data and select stay until the device has seen the edge
          wait_cnt <= wait_cnt + 32'h1;
          if (hold_end)
          begin
            bus.cs_n           <= 1'b1;
            bus.host_data_oe_n <= 1'b1;
            if (is_poll)
              device_ready <= (rsp_rdata != BUSY_READ);
            else
              rsp_valid <= 1'b1;
            state <= H_IDLE;
          end
        end
        default: state <= H_OFF;
      endcase
      if (!power_up_request)
      begin
        state              <= H_OFF;
        device_ready       <= 1'b0;
        bus.power_down_n   <= 1'b0;
        bus.cs_n           <= 1'b1;
        bus.rd_n           <= 1'b1;
        bus.wr_n           <= 1'b1;
        bus.host_data_oe_n <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- cics_chk.sv
/* Checker for the codec sequencer, fed from bus and device outputs.
   Assumes one clock, 32 clocks per sample period before any rate change. */
`default_nettype none
module cics_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic power_down_n,
  input wire logic dev_data_oe_n,
  input wire logic calibration_active,
  input wire logic dac_mute,
  input wire logic adc_data_valid,
  input wire logic dac_samples_accepted,
  input wire logic playback_request,
  input wire logic capture_request,
  input wire logic analog_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [13:0] cal_cnt; // Cycles in the current calibration
  ////////////////////////////////////////////////////////////////
  // Length counter; cleared when idle so each run counts alone
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cal_cnt <= 14'h0;
    else
      cal_cnt <= calibration_active ? cal_cnt + 14'h1 : 14'h0;
  // Sync delay of the pin is allowed for by the repeat count
  chk_pd_quiet: assert property (!power_down_n [*5] |-> dev_data_oe_n)
    else $error("bus driven in power down");
  chk_pd_analog: assert property (!power_down_n [*5] |-> !analog_enable)
    else $error("analog on in power down");
  chk_cal_len: assert property ($fell(calibration_active) |-> cal_cnt inside
    {[14'hfe0:14'h1428], [14'h2fe0:14'h3020]}) else $error("calibration length");
  chk_cal_xfer: assert property (calibration_active |-> !playback_request && !capture_request)
    else $error("transfer during calibration");
  chk_cal_mute: assert property (calibration_active |-> dac_mute)
    else $error("dac not muted");
  chk_cal_adc: assert property (calibration_active |-> !adc_data_valid)
    else $error("adc valid in calibration");
  chk_cal_dac: assert property (calibration_active |-> !dac_samples_accepted)
    else $error("dac samples taken");
  chk_pb_enable: assert property (playback_request |-> dac_samples_accepted)
    else $error("playback without enable");
endmodule
`default_nettype wire

//--- cics_test.sv
/* Bench joining host and device ends over the bus.
   Assumes a short settle count and calibration at the default rate. */
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("mismatch %0t: got %h want %h", $time, a, b); end end
module cics_test
  import cics_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       resetn, power_up_request, cmd_valid, cmd_write, cmd_ready, rsp_valid;
  logic       device_ready, calibration_active, dac_mute, adc_data_valid, offsets_valid;
  logic       dac_samples_accepted, playback_request, capture_request, analog_enable;
  logic [1:0] cmd_addr;
  logic [7:0] cmd_wdata, rsp_rdata;
  logic [2:0] mutes;  // Mix, second aux, first aux mute outputs
  int         fails, samples_checked;
  cics_bus_if bus ();
  cics_device cics_device_i (.clk, .resetn, .ce(1'b1), .bus(bus.device), .calibration_active,
    .playback_request, .capture_request, .dac_mute, .adc_data_valid, .dac_samples_accepted,
    .analog_enable, .offsets_valid, .first_auxiliary_input_mute(mutes[0]),
    .second_auxiliary_input_mute(mutes[1]), .digital_mix_mute(mutes[2]));
  cics_host #(.SETTLE(100)) cics_host_i (.clk, .resetn, .ce(1'b1), .power_up_request,
    .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata,
    .device_ready, .bus(bus.host));
  cics_chk cics_chk_i (.clk, .resetn, .power_down_n(bus.power_down_n),
    .dev_data_oe_n(bus.dev_data_oe_n), .calibration_active, .dac_mute, .adc_data_valid,
    .dac_samples_accepted, .playback_request, .capture_request, .analog_enable);
  ////////////////////////////////////////////////////////////////
  initial forever #12.5 clk = ~clk;
  // One host cycle, entered on a falling edge; bounded wait for the answer
  task automatic xfer(input logic w, input logic [1:0] a, input logic [7:0] d);
    {cmd_write, cmd_addr, cmd_wdata, cmd_valid} = {w, a, d, 1'b1};
    @(negedge clk) cmd_valid = 1'b0;
    repeat (64) if (rsp_valid !== 1'b1) @(negedge clk);
    `CHK(rsp_valid, 1'b1)
    @(negedge clk);
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    xfer(1'b1, ADR_INDEX, idx);
    xfer(1'b1, ADR_DATA, val);
  endtask
  task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b1, ADR_INDEX, idx);
    xfer(1'b0, ADR_DATA, 8'h00);
    `CHK(rsp_rdata, exp)
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Watchdog well past the longest sequence
  initial
  begin
    #1000000;
    fails++;
    end_of_test();
  end
  initial
  begin
    {resetn, power_up_request, cmd_valid, cmd_write, cmd_addr, cmd_wdata} = 14'h0000;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(bus.dev_data_oe_n, 1'b1)
    power_up_request = 1'b1;
    repeat (3000) if (device_ready !== 1'b1) @(negedge clk);
    `CHK(device_ready, 1'b1)
    chk_reg(8'h00, IFACE_RESET);
    chk_reg(8'h03, 8'h00);
    reg_wr(8'h01, 8'h02);
    chk_reg(8'h01, 8'h00);
    reg_wr(8'h03, 8'h07);
    `CHK(mutes, 3'h7)
    reg_wr(8'h40, 8'h09);
    xfer(1'b1, ADR_INDEX, 8'h02);
    repeat (160) if (calibration_active !== 1'b1) @(negedge clk);
    `CHK(calibration_active, 1'b1)
    chk_reg(8'h02, 8'h20);
    repeat (13000) if (calibration_active !== 1'b0) @(negedge clk);
    chk_reg(8'h02, 8'h01);
    reg_wr(8'h03, 8'h00);
    `CHK(mutes, 3'h0)
    reg_wr(8'h40, 8'h01);
    xfer(1'b1, ADR_INDEX, 8'h00);
    repeat (200) @(negedge clk);
    `CHK(calibration_active, 1'b0)
    `CHK(offsets_valid, 1'b1)
    reg_wr(8'h40, 8'h09);
    xfer(1'b1, ADR_INDEX, 8'h00);
    repeat (160) if (calibration_active !== 1'b1) @(negedge clk);
    `CHK(calibration_active, 1'b1)
    repeat (4500) if (calibration_active !== 1'b0) @(negedge clk);
    `CHK(calibration_active, 1'b0)
    reg_wr(8'h41, 8'h02);
    xfer(1'b0, ADR_INDEX, 8'h00);
    `CHK(rsp_rdata, BUSY_READ)
    xfer(1'b1, ADR_DATA, 8'h00);
    repeat (80) if (rsp_rdata !== 8'h41) xfer(1'b0, ADR_INDEX, 8'h00);
    `CHK(rsp_rdata, 8'h41)
    chk_reg(8'h41, 8'h02);
    end_of_test();
  end
endmodule
`default_nettype wire
